// ---- rtl/ccd_ctrl.sv ----
// Cache-coupled DRAM controller: decode, miss handling, parity
// ----------------------------------------------------------------
// How it works
// - cache and DRAM evaluate new cycle together
// - read hits and WB write hits finish in cache, DRAM idle
// - read miss writes dirty victim, then fills
// - write miss writes DRAM directly, no allocate
// - 128-byte read bursts, page-mode write-backs
// - memory data path 64 data plus 8 parity
// - one parity bit per byte, made and checked
// - four banks, two modules paired to run
// - boot ROM at top of 4GB and 1MB
// - first fetch after reset goes to ROM
// - shadow lets ROM code run from DRAM
// - 640KB base, extended above 1MB to 128MB
// - cache sized 256/512/1024KB, WB or WT
// ----------------------------------------------------------------
`timescale 1ns/1ps
`default_nettype none
module ccd_ctrl (
    input  wire logic                i_clk,        // System clock
    input  wire logic                i_rstn,       // Async reset, low
    input  wire logic                i_req,        // New cycle pulse
    input  wire ccd_pkg::ccd_req_type i_cpu,       // Cycle attributes
    input  wire ccd_pkg::ccd_tag_type i_tag,       // Tag lookup result
    input  wire logic [63:0]         i_line_rd,    // Victim data from cache
    input  wire logic [71:0]         i_mem_rd,     // DRAM read word
    input  wire logic [15:0]         i_shadow_en,  // Per 16 KB block
    input  wire logic                i_wback,      // 1 write-back, 0 thru
    input  wire logic [1:0]          i_csize,      // Cache size code
    input  wire logic [3:0]          i_bank_pres,  // Modules present
    output var  ccd_pkg::ccd_mem_type o_mem,       // DRAM cycle
    output logic                     o_mem_cyc,    // DRAM cycle active
    output logic [3:0]               o_bank_sel,   // Bank strobes
    output logic                     o_rom_sel,    // Boot ROM selected
    output logic                     o_cache_upd,  // Fill word to cache
    output logic [63:0]              o_rdata,      // Data to processor
    output logic                     o_rvalid,     // Read word valid
    output logic                     o_done,       // Cycle complete
    output logic                     o_par_err,    // Parity error pulse
    output logic                     o_mem_ok,     // Banks paired
    output logic [16:0]              o_cache_idx   // Index width by size
);
    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_IDLE, ST_WBACK, ST_FILL, ST_WRITE, ST_ROM, ST_DONE
    } ccd_st_type;
    ccd_st_type  st_r, st_nxt;              // Controller state
    logic [3:0]  beat_r, beat_nxt;          // Burst beat counter
    logic [31:0] addr_r, addr_nxt;          // Line address
    logic [31:0] vaddr_r, vaddr_nxt;        // Victim address
    logic [63:0] wdata_r, wdata_nxt;        // Held write data
    logic        boot_r, boot_nxt;          // First fetch pending
    ccd_pkg::ccd_mem_type mem_r, mem_nxt;   // Memory outputs
    logic        cyc_r, cyc_nxt;            // DRAM cycle active
    logic [3:0]  bank_r, bank_nxt;          // Bank strobes
    logic        rom_r, rom_nxt;            // ROM select
    logic        upd_r, upd_nxt;            // Cache update
    logic [63:0] rd_r, rd_nxt;              // Read data
    logic        rv_r, rv_nxt;              // Read valid
    logic        done_r, done_nxt;          // Done pulse
    logic        perr_r, perr_nxt;          // Parity error
    logic        ok_r, ok_nxt;              // Paired banks
    logic [16:0] idx_r, idx_nxt;            // Cache index
    ccd_pkg::ccd_tgt_type tgt;              // Decoded target
    logic [3:0]  blk;                       // Shadow block number

    // ----------------------------------------------------------------
    // Parity helpers
    // ----------------------------------------------------------------
    function automatic logic [71:0] add_par(input logic [63:0] d);
        logic [71:0] w;
        w = {8'h00, d};
        for (int i = 0; i < ccd_pkg::PAR_W; i++) begin
            w[ccd_pkg::DATA_W + i] = ^d[8*i +: 8];
        end
        return w;
    endfunction : add_par

    function automatic logic par_bad(input logic [71:0] w);
        logic b;
        b = 1'b0;
        for (int i = 0; i < ccd_pkg::PAR_W; i++) begin
            b = b | (^w[8*i +: 8] ^ w[ccd_pkg::DATA_W + i]);
        end
        return b;
    endfunction : par_bad

    // ----------------------------------------------------------------
    // Address decode
    // ----------------------------------------------------------------
    always_comb begin
        blk = i_cpu.addr[17:14];
        if (boot_r) begin
            tgt = ccd_pkg::TGT_ROM;
        end else if (i_cpu.addr >= ccd_pkg::HI_ROM_BASE) begin
            tgt = ccd_pkg::TGT_ROM;
        end else if (i_cpu.addr >= ccd_pkg::SHADOW_BASE &&
                     i_cpu.addr < ccd_pkg::ONE_MB) begin
            // Shadowed blocks run from DRAM; others reach the ROM, except writes below LO_ROM_BASE
            if (i_shadow_en[blk]) begin
                tgt = ccd_pkg::TGT_DRAM;
            end else if (i_cpu.addr >= ccd_pkg::LO_ROM_BASE ||
                         !i_cpu.wr) begin
                tgt = ccd_pkg::TGT_ROM;
            end else begin
                tgt = ccd_pkg::TGT_NONE;
            end
        end else if (i_cpu.addr < ccd_pkg::BASE_TOP ||
                     (i_cpu.addr >= ccd_pkg::ONE_MB &&
                      i_cpu.addr < ccd_pkg::DRAM_TOP)) begin
            tgt = ccd_pkg::TGT_DRAM;
        end else begin
            tgt = ccd_pkg::TGT_NONE;
        end
    end

    // ----------------------------------------------------------------
    // Next-state logic
    // ----------------------------------------------------------------
    always_comb begin
        st_nxt    = st_r;
        beat_nxt  = beat_r;
        addr_nxt  = addr_r;
        vaddr_nxt = vaddr_r;
        wdata_nxt = wdata_r;
        boot_nxt  = boot_r;
        mem_nxt   = mem_r;
        cyc_nxt   = 1'b0;
        bank_nxt  = 4'h0;
        rom_nxt   = 1'b0;
        upd_nxt   = 1'b0;
        rd_nxt    = rd_r;
        rv_nxt    = 1'b0;
        done_nxt  = 1'b0;
        perr_nxt  = 1'b0;
        // Two modules per 64-bit bank pair must be present
        ok_nxt    = (i_bank_pres[0] & i_bank_pres[1]) |
                    (i_bank_pres[2] & i_bank_pres[3]);
        // Index width follows cache size code
        case (i_csize)
            ccd_pkg::CSZ_256K:  idx_nxt = {2'h0, i_cpu.addr[17:3]};
            ccd_pkg::CSZ_512K:  idx_nxt = {1'h0, i_cpu.addr[18:3]};
            ccd_pkg::CSZ_1024K: idx_nxt = i_cpu.addr[19:3];
            default:            idx_nxt = {2'h0, i_cpu.addr[17:3]};
        endcase
        case (st_r)
            ST_IDLE: begin
                // Decode in parallel with the tag lookup
                if (i_req) begin
                    addr_nxt  = {i_cpu.addr[31:7], 7'h00};
                    vaddr_nxt = {i_tag.vaddr[31:7], 7'h00};
                    wdata_nxt = i_cpu.wdata;
                    beat_nxt  = 4'h0;
                    if (tgt == ccd_pkg::TGT_ROM) begin
                        boot_nxt = 1'b0;
                        st_nxt   = ST_ROM;
                    end else if (tgt == ccd_pkg::TGT_NONE) begin
                        st_nxt = ST_DONE;
                    end else if (i_tag.hit) begin
                        // Cache serves it; write-thru also writes DRAM
                        if (i_cpu.wr && !i_wback) begin
                            addr_nxt = i_cpu.addr;
                            st_nxt   = ST_WRITE;
                        end else begin
                            st_nxt = ST_IDLE;
                        end
                    end else if (i_cpu.wr) begin
                        addr_nxt = i_cpu.addr;
                        st_nxt   = ST_WRITE;
                    end else if (i_tag.dirty && i_wback) begin
                        st_nxt = ST_WBACK;
                    end else begin
                        st_nxt = ST_FILL;
                    end
                end
            end
            ST_WBACK: begin
                // Page-mode beats of the victim line
                cyc_nxt     = 1'b1;
                bank_nxt    = vaddr_r[26] ? 4'hc : 4'h3;
                mem_nxt.we  = 1'b1;
                mem_nxt.addr  = vaddr_r + {25'h0, beat_r, 3'h0};
                mem_nxt.wdata = add_par(i_line_rd);
                beat_nxt    = beat_r + 4'h1;
                if (beat_r == ccd_pkg::BURST_LAST) begin
                    beat_nxt = 4'h0;
                    st_nxt   = ST_FILL;
                end
            end
            ST_FILL: begin
                // 128-byte read burst to processor and cache
                cyc_nxt      = 1'b1;
                bank_nxt     = addr_r[26] ? 4'hc : 4'h3;
                mem_nxt.we   = 1'b0;
                mem_nxt.addr = addr_r + {25'h0, beat_r, 3'h0};
                rd_nxt       = i_mem_rd[63:0];
                rv_nxt       = 1'b1;
                upd_nxt      = 1'b1;
                perr_nxt     = par_bad(i_mem_rd);
                beat_nxt     = beat_r + 4'h1;
                if (beat_r == ccd_pkg::BURST_LAST) begin
                    st_nxt = ST_DONE;
                end
            end
            ST_WRITE: begin
                cyc_nxt       = 1'b1;
                bank_nxt      = addr_r[26] ? 4'hc : 4'h3;
                mem_nxt.we    = 1'b1;
                mem_nxt.addr  = addr_r;
                mem_nxt.wdata = add_par(wdata_r);
                st_nxt        = ST_DONE;
            end
            ST_ROM: begin
                rom_nxt = 1'b1;
                st_nxt  = ST_DONE;
            end
            ST_DONE: begin
                done_nxt = 1'b1;
                st_nxt   = ST_IDLE;
            end
            default: st_nxt = ST_IDLE;
        endcase
    end

    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            st_r <= ST_IDLE;
            beat_r <= 4'h0;
            addr_r <= 32'h0000_0000;
            vaddr_r <= 32'h0000_0000;
            wdata_r <= 64'h0;
            boot_r <= 1'b1;
            mem_r <= '0;
            cyc_r <= 1'b0;
            bank_r <= 4'h0;
            rom_r <= 1'b0;
            upd_r <= 1'b0;
            rd_r <= 64'h0;
            rv_r <= 1'b0;
            done_r <= 1'b0;
            perr_r <= 1'b0;
            ok_r <= 1'b0;
            idx_r <= 17'h0;
        end else begin
            st_r <= st_nxt;
            beat_r <= beat_nxt;
            addr_r <= addr_nxt;
            vaddr_r <= vaddr_nxt;
            wdata_r <= wdata_nxt;
            boot_r <= boot_nxt;
            mem_r <= mem_nxt;
            cyc_r <= cyc_nxt;
            bank_r <= bank_nxt;
            rom_r <= rom_nxt;
            upd_r <= upd_nxt;
            rd_r <= rd_nxt;
            rv_r <= rv_nxt;
            done_r <= done_nxt;
            perr_r <= perr_nxt;
            ok_r <= ok_nxt;
            idx_r <= idx_nxt;
        end
    end

    assign o_mem       = mem_r;
    assign o_mem_cyc   = cyc_r;
    assign o_bank_sel  = bank_r;
    assign o_rom_sel   = rom_r;
    assign o_cache_upd = upd_r;
    assign o_rdata     = rd_r;
    assign o_rvalid    = rv_r;
    assign o_done      = done_r;
    assign o_par_err   = perr_r;
    assign o_mem_ok    = ok_r;
    assign o_cache_idx = idx_r;

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rstn);

    hit_idle_a: assert property (
        (st_r == ST_IDLE && i_req && i_tag.hit && !i_cpu.wr &&
         tgt == ccd_pkg::TGT_DRAM) |=> !cyc_r [*2])
        else $error("DRAM active on read hit");
    parallel_eval_a: assert property (
        (st_r == ST_IDLE && i_req && !i_tag.hit && i_cpu.wr &&
         tgt == ccd_pkg::TGT_DRAM) |=> st_r == ST_WRITE)
        else $error("Miss not taken at once");
    wback_first_a: assert property (
        (st_r == ST_WBACK && beat_r == ccd_pkg::BURST_LAST)
        |=> st_r == ST_FILL)
        else $error("Fill did not follow write-back");
    write_miss_a: assert property (
        st_r == ST_WRITE |=> cyc_r && mem_r.we && !upd_r)
        else $error("Write miss not direct");
    burst_len_a: assert property (
        ($rose(st_r == ST_FILL)) |=> rv_r [*8] ##0 1'b1 ##1 rv_r [*8])
        else $error("Burst shorter than 16 beats");
    par_gen_a: assert property (
        (cyc_r && mem_r.we) |-> mem_r.wdata[64] == ^mem_r.wdata[7:0])
        else $error("Byte parity wrong");
    boot_rom_a: assert property (
        (boot_r && i_req && st_r == ST_IDLE) |=> ##1 rom_r)
        else $error("First fetch not to ROM");
    hi_rom_a: assert property (
        (st_r == ST_IDLE && i_req && i_cpu.addr >= ccd_pkg::HI_ROM_BASE)
        |=> st_r == ST_ROM)
        else $error("High ROM alias missed");
    pair_a: assert property (
        (i_bank_pres == 4'h1) |=> !ok_r)
        else $error("Single module reported ok");
    noshadow_a: assert property (
        (st_r == ST_IDLE && i_req && !boot_r && !i_cpu.wr &&
         i_cpu.addr >= ccd_pkg::LO_ROM_BASE &&
         i_cpu.addr < ccd_pkg::ONE_MB && !i_shadow_en[blk])
        |=> st_r == ST_ROM)
        else $error("Unshadowed read went to DRAM");

    fill_cv: cover property (st_r == ST_FILL ##1 st_r == ST_DONE);
    wback_cv: cover property (st_r == ST_WBACK);
    wmiss_cv: cover property (st_r == ST_WRITE);
    rom_cv: cover property (rom_r);
endmodule : ccd_ctrl
`default_nettype wire

// ---- rtl/ccd_pkg.sv ----
// Package: shared constants and carrier types for the cache-coupled DRAM control
package ccd_pkg;
    // ----------------------------------------------------------------
    // Memory map
    // ----------------------------------------------------------------
    localparam logic [31:0] BASE_TOP      = 32'h000a_0000; // 640 KB base DRAM
    localparam logic [31:0] ONE_MB        = 32'h0010_0000; // Extended start
    localparam logic [31:0] DRAM_TOP      = 32'h0800_0000; // 128 MB total
    localparam logic [31:0] HI_ROM_BASE   = 32'hfffe_0000; // Top 128 KB of 4 GB
    localparam logic [31:0] LO_ROM_BASE   = 32'h000e_0000; // Top 128 KB of 1 MB
    localparam logic [31:0] SHADOW_BASE   = 32'h000c_0000; // First shadow block
    localparam logic [31:0] RESET_VECTOR  = 32'hffff_fff0; // First fetch
    localparam int          SHADOW_SHIFT  = 14;            // 16 KB blocks
    localparam int          SHADOW_BLOCKS = 16;            // C0000..FFFFF
    // ----------------------------------------------------------------
    // Data path and burst
    // ----------------------------------------------------------------
    localparam int          DATA_W        = 64;            // Data bits
    localparam int          PAR_W         = 8;             // One per byte
    localparam int          MEM_W         = 72;            // Data plus parity
    localparam int          BURST_BYTES   = 128;           // Read burst
    localparam logic [3:0]  BURST_LAST    = 4'hf;          // 128 / 8 - 1
    localparam int          NUM_BANKS     = 4;             // Banks of by-36
    // ----------------------------------------------------------------
    // Cache size encodings
    // ----------------------------------------------------------------
    localparam logic [1:0]  CSZ_256K      = 2'h0;          // 256 KB
    localparam logic [1:0]  CSZ_512K      = 2'h1;          // 512 KB
    localparam logic [1:0]  CSZ_1024K     = 2'h2;          // 1024 KB
    // ----------------------------------------------------------------
    // Types
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        TGT_NONE, TGT_DRAM, TGT_ROM
    } ccd_tgt_type;
    typedef struct packed {
        logic [31:0] addr;      // Processor address
        logic        wr;        // Write cycle
        logic [63:0] wdata;     // Write data
    } ccd_req_type;
    typedef struct packed {
        logic        hit;       // Cache tag hit
        logic        dirty;     // Victim line dirty
        logic [31:0] vaddr;     // Victim line address
    } ccd_tag_type;
    typedef struct packed {
        logic [31:0] addr;      // DRAM word address
        logic        we;        // Write strobe
        logic [71:0] wdata;     // Data plus parity
    } ccd_mem_type;
endpackage : ccd_pkg

// ---- tb/ccd_host_model.sv ----
// Host-side data source: victim line words and DRAM read words
`timescale 1ns/1ps
`default_nettype none
module ccd_host_model #(
    parameter logic [63:0] MEM_PAT  = 64'h0, // DRAM word pattern
    parameter logic [63:0] LINE_PAT = 64'h0  // Cache victim pattern
) (
    input  wire logic        i_bad_par, // Flip byte 0 parity
    output logic [63:0]      o_line_rd, // Victim word to controller
    output logic [71:0]      o_mem_rd   // DRAM word, parity on top
);
    // Even parity per byte, one bit for each byte lane
    function automatic logic [7:0] par_of(input logic [63:0] d);
        for (int b = 0; b < 8; b++) begin
            par_of[b] = ^d[8*b +: 8];
        end
    endfunction : par_of

    // Words stay stable for a whole line, so beat timing cannot skew them
    assign o_line_rd = LINE_PAT;
    assign o_mem_rd  = {par_of(MEM_PAT) ^ {7'h00, i_bad_par}, MEM_PAT};
endmodule : ccd_host_model
`default_nettype wire

// ---- tb/test_cache_coupled_dram_control.sv ----
// Testbench: directed scenarios for the cache-coupled DRAM control
`timescale 1ns/1ps
`default_nettype none
module test_cache_coupled_dram_control;
    localparam logic [63:0] MEM_PAT  = 64'h3c5a_0f96_e187_2d41;
    localparam logic [63:0] LINE_PAT = 64'h0123_4567_89ab_cd03;
    localparam logic [63:0] WR_PAT   = 64'h00ff_1234_a5c3_7e81;
    logic clk, rstn, req, wback, bad_par, mem_cyc, rom_sel, cache_upd;
    logic rvalid, done, par_err, mem_ok;
    logic [15:0] shadow;
    logic [1:0]  csize;
    logic [3:0]  bank_pres, bank_sel, bs_seen;
    logic [63:0] line_rd, rdata, rd_seen;
    logic [71:0] mem_rd, wd;
    logic [16:0] cache_idx;
    logic [31:0] wa[$], ra[$];
    ccd_pkg::ccd_req_type cpu;
    ccd_pkg::ccd_tag_type tag;
    ccd_pkg::ccd_mem_type mem;
    int n_fail, comparisons, t_rom, t_done, n_rd, n_upd, n_err, t_lw, t_fr;

    ccd_ctrl ccd_ctrl_inst (.i_clk(clk), .i_rstn(rstn), .i_req(req),
        .i_cpu(cpu), .i_tag(tag), .i_line_rd(line_rd), .i_mem_rd(mem_rd),
        .i_shadow_en(shadow), .i_wback(wback), .i_csize(csize),
        .i_bank_pres(bank_pres), .o_mem(mem), .o_mem_cyc(mem_cyc),
        .o_bank_sel(bank_sel), .o_rom_sel(rom_sel),
        .o_cache_upd(cache_upd), .o_rdata(rdata), .o_rvalid(rvalid),
        .o_done(done), .o_par_err(par_err), .o_mem_ok(mem_ok),
        .o_cache_idx(cache_idx));
    ccd_host_model #(.MEM_PAT(MEM_PAT), .LINE_PAT(LINE_PAT))
        ccd_host_model_inst (.i_bad_par(bad_par), .o_line_rd(line_rd),
        .o_mem_rd(mem_rd));

    // 100 MHz clock
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic check(input string name, input logic [71:0] seen,
                         input logic [71:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_fail++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task automatic results();
        if (n_fail == 0 && comparisons > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : results

    // Tb-side even parity, used only to judge write-miss and write-back words
    function automatic logic [7:0] epar(input logic [63:0] d);
        for (int b = 0; b < 8; b++) begin
            epar[b] = ^d[8*b +: 8];
        end
    endfunction : epar

    // One processor cycle; records what the controller does until done, for at most 40 clocks
    task automatic run_cycle(input logic [31:0] addr, input logic wr,
                             input logic hit, input logic dirty,
                             input logic [31:0] vaddr);
        @(negedge clk);
        req = 1'b1;
        cpu = '{addr: addr, wr: wr, wdata: WR_PAT};
        tag = '{hit: hit, dirty: dirty, vaddr: vaddr};
        @(negedge clk);
        req = 1'b0;
        {t_rom, t_done, n_rd, n_upd, n_err, t_lw, t_fr} = '0;
        bs_seen = 4'h0;
        wa.delete();
        ra.delete();
        // k is the cycle number; the request stood in cycle 1
        for (int k = 2; k <= 41 && t_done == 0; k++) begin
            @(posedge clk);
            #1;
            if (rom_sel === 1'b1) t_rom = k;
            if (done === 1'b1) t_done = k;
            if (rvalid === 1'b1) n_rd++;
            if (rvalid === 1'b1) rd_seen = rdata;
            if (cache_upd === 1'b1) n_upd++;
            if (par_err === 1'b1) n_err++;
            if (mem_cyc === 1'b1) begin
                bs_seen = bs_seen | bank_sel;
                if (mem.we === 1'b1) begin
                    wa.push_back(mem.addr);
                    wd = mem.wdata;
                    t_lw = k;
                end else begin
                    ra.push_back(mem.addr);
                    if (t_fr == 0) t_fr = k;
                end
            end
        end
        // Hand back on a falling edge, where stimulus may change
        @(negedge clk);
    endtask : run_cycle

    // Checks a line of 16 ascending beats from a base address
    task automatic check_line(input logic [31:0] base, input logic is_wr);
        check("beat count", is_wr ? wa.size() : ra.size(), 16);
        for (int i = 0; i < 16 && i < (is_wr ? wa.size() : ra.size()); i++)
            check("beat addr", is_wr ? wa[i] : ra[i], base + 8 * i);
    endtask : check_line

    task automatic t_boot();
        check("outs after reset", {mem_cyc, rom_sel, rvalid, done}, 0);
        run_cycle(32'h0000_1000, 1'b0, 1'b0, 1'b0, 32'h0);
        check("boot rom sel", t_rom, 2);
        check("boot done", t_done, 3);
        check("boot dram", wa.size() + ra.size(), 0);
    endtask : t_boot

    task automatic t_hit();
        run_cycle(32'h0000_2000, 1'b0, 1'b1, 1'b0, 32'h0);
        check("rd hit dram", ra.size() + n_rd + t_done, 0);
        run_cycle(32'h0000_2008, 1'b1, 1'b1, 1'b0, 32'h0);
        check("wr hit dram", wa.size() + t_done, 0);
        // Write-through policy: a write hit also goes to DRAM
        wback = 1'b0;
        run_cycle(32'h0000_2010, 1'b1, 1'b1, 1'b0, 32'h0);
        wback = 1'b1;
        check("wt hit write", wa.size(), 1);
        check("wt hit addr", wa[0], 32'h0000_2010);
        check("wt hit done", t_done, 3);
    endtask : t_hit

    task automatic t_wmiss();
        run_cycle(32'h0000_3008, 1'b1, 1'b0, 1'b0, 32'h0);
        check("wmiss beats", wa.size(), 1);
        check("wmiss addr", wa[0], 32'h0000_3008);
        check("wmiss data", wd[63:0], WR_PAT);
        check("wmiss parity", wd[71:64], epar(WR_PAT));
        check("wmiss no fill", n_upd + ra.size(), 0);
        check("wmiss done", t_done, 3);
        check("wmiss banks", bs_seen, 4'h3);
    endtask : t_wmiss

    task automatic t_read(output int errs);
        run_cycle(32'h0001_0048, 1'b0, 1'b0, 1'b0, 32'h0);
        check_line(32'h0001_0000, 1'b0);
        check("fill upd", n_upd, 16);
        check("fill valid", n_rd, 16);
        check("fill data", rd_seen, MEM_PAT);
        check("clean no wb", wa.size(), 0);
        check("clean done", t_done, 18);
        errs = n_err;
    endtask : t_read

    task automatic t_dirty();
        run_cycle(32'h0400_0080, 1'b0, 1'b0, 1'b1, 32'h0400_1100);
        check_line(32'h0400_1100, 1'b1);
        check_line(32'h0400_0080, 1'b0);
        check("wb first", t_fr > t_lw, 1'b1);
        check("wb data", wd[63:0], LINE_PAT);
        check("wb parity", wd[71:64], epar(LINE_PAT));
        check("dirty done", t_done, 34);
        check("upper banks", bs_seen, 4'hc);
    endtask : t_dirty

    task automatic t_par(input int good_errs);
        int bad_errs;
        bad_par = 1'b1;
        t_read(bad_errs);
        bad_par = 1'b0;
        check("parity flags", good_errs + bad_errs, 16);
        check("parity clean", good_errs, 0);
    endtask : t_par

    // Address decode: 0 unmapped, 1 DRAM line fill, 2 boot ROM
    task automatic t_map();
        logic [31:0] a_tab[9] = '{ccd_pkg::HI_ROM_BASE + 32'h100,
            ccd_pkg::LO_ROM_BASE + 32'h100, ccd_pkg::LO_ROM_BASE + 32'h100,
            ccd_pkg::SHADOW_BASE, ccd_pkg::SHADOW_BASE,
            ccd_pkg::BASE_TOP - 32'h8, ccd_pkg::ONE_MB,
            ccd_pkg::DRAM_TOP - 32'h8, ccd_pkg::DRAM_TOP};
        logic [15:0] s_tab[9] = '{16'h0, 16'h0, 16'h0100, 16'h0001, 16'h0,
            16'hffff, 16'h0, 16'h0, 16'h0};
        int e_tab[9] = '{2, 2, 1, 1, 2, 1, 1, 1, 0};
        for (int i = 0; i < 9; i++) begin
            shadow = s_tab[i];
            run_cycle(a_tab[i], 1'b0, 1'b0, 1'b0, 32'h0);
            check("map rom", t_rom == 2, e_tab[i] == 2);
            check("map dram", ra.size() == 16, e_tab[i] == 1);
        end
        shadow = 16'h0;
    endtask : t_map

    task automatic t_banks();
        logic [3:0] p_tab[5] = '{4'h3, 4'hc, 4'h1, 4'ha, 4'h0};
        for (int i = 0; i < 5; i++) begin
            bank_pres = p_tab[i];
            repeat (2) @(negedge clk);
            check("mem ok", mem_ok, i < 2);
        end
        bank_pres = 4'hf;
    endtask : t_banks

    task automatic t_idx();
        logic [16:0] i_tab[3] = '{17'h07fff, 17'h0ffff, 17'h1ffff};
        for (int i = 0; i < 3; i++) begin
            csize = i[1:0];
            run_cycle(32'h07ff_fff8, 1'b0, 1'b1, 1'b0, 32'h0);
            check("cache index", cache_idx, i_tab[i]);
        end
    endtask : t_idx

    // Reset, then the scenarios in sequence
    initial begin
        int good_errs;
        {rstn, req, bad_par, shadow, csize} = '0;
        {wback, bank_pres} = 5'h1f;
        cpu = '0;
        tag = '0;
        repeat (16) @(posedge clk);
        @(negedge clk);
        rstn = 1'b1;
        t_boot();
        t_hit();
        t_wmiss();
        t_read(good_errs);
        t_dirty();
        t_par(good_errs);
        t_map();
        t_banks();
        t_idx();
        results();
    end

    // Watchdog well past the expected run length
    initial begin
        #100us;
        n_fail++;
        results();
    end
endmodule : test_cache_coupled_dram_control
`default_nettype wire
